// [common/pio_consts.svh]
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
// ----------------------------------------------------------------
// widths of the three ports
// ----------------------------------------------------------------
`define PIO_PA_W 13
`define PIO_PB_W 12
`define PIO_PN_W 8
`define PIO_RAW_W 33
// ----------------------------------------------------------------
// offsets of each port inside the synchroniser vector
// ----------------------------------------------------------------
`define PIO_RAW_PA_LSB 0
`define PIO_RAW_PB_LSB 13
`define PIO_RAW_PN_LSB 25
// ----------------------------------------------------------------
// implemented register bits, reserved bits stay zero
// ----------------------------------------------------------------
`define PIO_PA_FUNC_MASK 16'h17FF
`define PIO_PA_DIR_MASK 16'h1FFF
`define PIO_PA_PIN_MASK 16'h17FF
`define PIO_PB_FUNC_MASK 16'h00E8
`define PIO_PB_DIR_MASK 16'h0FFF
`define PIO_PB_PIN_MASK 16'h0FE8
`define PIO_PN_MASK 16'hFF00
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PIO_PA_FUNC_RST 16'h0000
`define PIO_PA_DIR_RST 16'h0000
`define PIO_PB_FUNC_RST 16'h0080
`define PIO_PB_DIR_RST 16'h0000
`define PIO_PN_DIR_RST_SAFE 16'h0000
`define PIO_VAL_RST 16'h0000
// ----------------------------------------------------------------
// bit positions with dedicated uses
// ----------------------------------------------------------------
`define PIO_PA_RX_CLOCK_BIT 2
`define PIO_PA_TX_CLOCK_BIT 3
`define PIO_PA_CP_RX_BIT 8
`define PIO_PA_CP_TX_BIT 9
`define PIO_PA_CP_CLOCK_BIT 10
`define PIO_PA_STRAP_BIT 12
`define PIO_PB_TIMER_ONE_BIT 3
`define PIO_PB_TIMER_TWO_IN_BIT 5
`define PIO_PB_TIMER_TWO_OUT_BIT 6
`define PIO_PB_WATCHDOG_BIT 7
`define PIO_PB_LINE_EIGHT_BIT 8
`define PIO_PB_IRQ_LSB 8
`define PIO_PB_IRQ_W 4
`define PIO_PN_LSB 8
`endif

// [common/pio_pkg.sv]
// ----------------------------------------------------------------
// register selection codes for the write port
// ----------------------------------------------------------------
package pio_pkg;
   typedef enum logic [2:0] {
      PIO_REG_PA_FUNC,
      PIO_REG_PA_DIR,
      PIO_REG_PA_VAL,
      PIO_REG_PB_FUNC,
      PIO_REG_PB_DIR,
      PIO_REG_PB_VAL,
      PIO_REG_PN_DIR,
      PIO_REG_PN_VAL
   } pio_reg_t;
   typedef logic [15:0] pio_word_t;
endpackage : pio_pkg

// [common/pio_sync_if.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pio_consts.svh"
// ----------------------------------------------------------------
// raw pin levels in, synchronised levels out
// ----------------------------------------------------------------
interface pio_sync_if;
   logic [`PIO_RAW_W-1:0] raw; // pin levels as seen at the pads
   logic [`PIO_RAW_W-1:0] sync; // levels after two flip-flops
   modport syncer (input raw, output sync);
   modport user (output raw, input sync);
endinterface : pio_sync_if
`default_nettype wire

// [src/pio_sync.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pio_consts.svh"
// ----------------------------------------------------------------
// two flip-flop synchroniser for every input pin
// ----------------------------------------------------------------
module pio_sync (
   input wire logic MCLK, // system clock
   input wire logic ARST_N, // asynchronous reset, active low
   pio_sync_if.syncer pins // raw in, synchronised out
);
   logic [`PIO_RAW_W-1:0] meta_reg; // first stage, read only by second
   logic [`PIO_RAW_W-1:0] sync_reg; // second stage, safe to use

   // first stage feeds nothing but the second stage
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= pins.raw;
         sync_reg <= meta_reg;
      end
   end

   assign pins.sync = sync_reg;
endmodule : pio_sync
`default_nettype wire

// [src/pio_edge.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pio_consts.svh"
// ----------------------------------------------------------------
// falling edge detector for the interrupt capable lines
// ----------------------------------------------------------------
module pio_edge (
   input wire logic MCLK, // system clock
   input wire logic ARST_N, // asynchronous reset, active low
   input wire logic [`PIO_PB_IRQ_W-1:0] level, // synchronised levels
   input wire logic [`PIO_PB_IRQ_W-1:0] enable, // line may raise request
   output logic [`PIO_PB_IRQ_W-1:0] request // one clock pulse per edge
);
   logic [`PIO_PB_IRQ_W-1:0] prev_reg; // level one clock ago
   logic [`PIO_PB_IRQ_W-1:0] req_reg; // registered request pulses
   logic [`PIO_PB_IRQ_W-1:0] req_next; // high then low, enabled lines
   // low reset value: a pin already high at release gives no edge
   assign req_next = prev_reg & ~level & enable;

   // history and pulse registers
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prev_reg <= '0;
         req_reg <= '0;
      end else begin
         prev_reg <= level;
         req_reg <= req_next;
      end
   end

   assign request = req_reg;
endmodule : pio_edge
`default_nettype wire

// [src/pio_ports.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pio_consts.svh"
module pio_ports
   import pio_pkg::*;
(
   input wire logic MCLK, // system clock, 50 MHz
   input wire logic ARST_N, // total system reset, active low
   input wire logic WR_EN, // one clock register write strobe
   input wire logic [2:0] WR_SEL, // register picked by the write
   input wire logic [15:0] WR_DATA, // write data
   output logic [15:0] PA_RD, // port A value readback
   output logic [15:0] PB_RD, // port B value readback
   output logic [15:0] PN_RD, // port N value readback
   output logic [15:0] PA_FUNC_RD, // port A function select readback
   output logic [15:0] PA_DIR_RD, // port A direction readback
   output logic [15:0] PB_FUNC_RD, // port B function select readback
   output logic [15:0] PB_DIR_RD, // port B direction readback
   output logic [15:0] PN_DIR_RD, // port N direction readback
   input wire logic [12:0] PA_PIN_I, // port A pad levels
   output logic [12:0] PA_PIN_O, // port A pad drive levels
   output logic [12:0] PA_PIN_OE, // port A pad drive enables
   input wire logic [12:0] PA_PERIPH_O, // serial peripherals drive
   input wire logic [12:0] PA_PERIPH_OE, // serial peripherals enables
   output logic [12:0] PA_PERIPH_I, // levels to serial peripherals
   input wire logic [11:0] PB_PIN_I, // port B pad levels
   output logic [11:0] PB_PIN_O, // port B pad drive levels
   output logic [11:0] PB_PIN_OE, // port B pad drive enables
   input wire logic TIMER_TWO_OUTPUT, // timer two output level
   input wire logic WATCHDOG_OUT_N, // watchdog event, active low
   output logic TIMER_ONE_INPUT, // level to timer one
   output logic TIMER_TWO_INPUT, // level to timer two
   input wire logic REFRESH_SELECT, // line eight used for refresh
   output logic REFRESH_REQ, // refresh request level
   input wire logic PERIODIC_TICK_ENABLE, // tick timer running
   output logic [3:0] PB_IRQ, // line 8-11 request pulses
   input wire logic [7:0] PN_PIN_I, // port N pad levels
   output logic [7:0] PN_PIN_O, // port N pad drive levels
   output logic [7:0] PN_PIN_OE, // port N pad drive enables
   input wire logic BUS_WIDTH_SELECT, // zero means narrow bus mode
   output logic CLOCK_MODE_STRAP // strap level caught at release
);
   // ----------------------------------------------------------------
   // read mux shared by all three ports
   // ----------------------------------------------------------------
   // outputs return the stored bit, inputs the pin, absent inputs zero
   function automatic logic [15:0] pio_read(
      input logic [15:0] dir,
      input logic [15:0] val,
      input logic [15:0] pin,
      input logic [15:0] present
   );
      pio_read = (dir & val) | (~dir & pin & present);
   endfunction : pio_read

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   pio_sync_if sync_bus (); // carrier for raw and synced pins
   assign sync_bus.raw = {PN_PIN_I, PB_PIN_I, PA_PIN_I};

   pio_sync u_sync (
      .MCLK (MCLK),
      .ARST_N (ARST_N),
      .pins (sync_bus.syncer)
   );

   logic [15:0] pa_sync; // port A synchronised, widened
   logic [15:0] pb_sync; // port B synchronised, widened
   logic [15:0] pn_sync; // port N synchronised, upper byte
   assign pa_sync = {3'h0,
      sync_bus.sync[`PIO_RAW_PA_LSB +: `PIO_PA_W]};
   assign pb_sync = {4'h0,
      sync_bus.sync[`PIO_RAW_PB_LSB +: `PIO_PB_W]};
   assign pn_sync = {sync_bus.sync[`PIO_RAW_PN_LSB +: `PIO_PN_W],
      8'h00};

   // ----------------------------------------------------------------
   // configuration and value registers
   // ----------------------------------------------------------------
   pio_word_t pa_func_reg, pa_func_next; // port A function select
   pio_word_t pa_dir_reg, pa_dir_next; // port A direction
   pio_word_t pa_val_reg, pa_val_next; // port A stored value
   pio_word_t pb_func_reg, pb_func_next; // port B function select
   pio_word_t pb_dir_reg, pb_dir_next; // port B direction
   pio_word_t pb_val_reg, pb_val_next; // port B stored value
   pio_word_t pn_dir_reg, pn_dir_next; // port N direction
   pio_word_t pn_val_reg, pn_val_next; // port N stored value

   logic [7:0] wr_hit; // one-hot decode of the write
   assign wr_hit = WR_EN ? (8'h01 << WR_SEL) : 8'h00;

   // masking on write keeps reserved bits at zero for every read
   assign pa_func_next = wr_hit[PIO_REG_PA_FUNC] ?
      (WR_DATA & `PIO_PA_FUNC_MASK) : pa_func_reg;
   assign pa_dir_next = wr_hit[PIO_REG_PA_DIR] ?
      (WR_DATA & `PIO_PA_DIR_MASK) : pa_dir_reg;
   assign pa_val_next = wr_hit[PIO_REG_PA_VAL] ?
      (WR_DATA & `PIO_PA_DIR_MASK) : pa_val_reg;
   // no select bits above line seven: lines 9-11 stay general, line eight leaves only for REFRESH_SELECT
   assign pb_func_next = wr_hit[PIO_REG_PB_FUNC] ?
      (WR_DATA & `PIO_PB_FUNC_MASK) : pb_func_reg;
   assign pb_dir_next = wr_hit[PIO_REG_PB_DIR] ?
      (WR_DATA & `PIO_PB_DIR_MASK) : pb_dir_reg;
   assign pb_val_next = wr_hit[PIO_REG_PB_VAL] ?
      (WR_DATA & `PIO_PB_DIR_MASK) : pb_val_reg;
   assign pn_dir_next = wr_hit[PIO_REG_PN_DIR] ?
      (WR_DATA & `PIO_PN_MASK) : pn_dir_reg;
   assign pn_val_next = wr_hit[PIO_REG_PN_VAL] ?
      (WR_DATA & `PIO_PN_MASK) : pn_val_reg;

   // port A registers, all cleared: every pin a general input
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pa_func_reg <= `PIO_PA_FUNC_RST;
         pa_dir_reg <= `PIO_PA_DIR_RST;
         pa_val_reg <= `PIO_VAL_RST;
      end else begin
         pa_func_reg <= pa_func_next;
         pa_dir_reg <= pa_dir_next;
         pa_val_reg <= pa_val_next;
      end
   end

   // port B registers, line seven starts as the watchdog
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pb_func_reg <= `PIO_PB_FUNC_RST;
         pb_dir_reg <= `PIO_PB_DIR_RST;
         pb_val_reg <= `PIO_VAL_RST;
      end else begin
         pb_func_reg <= pb_func_next;
         pb_dir_reg <= pb_dir_next;
         pb_val_reg <= pb_val_next;
      end
   end

   // port N registers
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pn_dir_reg <= `PIO_PN_DIR_RST_SAFE;
         pn_val_reg <= `PIO_VAL_RST;
      end else begin
         pn_dir_reg <= pn_dir_next;
         pn_val_reg <= pn_val_next;
      end
   end

   // ----------------------------------------------------------------
   // port A pad drive
   // ----------------------------------------------------------------
   logic [12:0] pa_gp_oe; // general output enables
   logic [12:0] pa_o_next; // pad level choice
   logic [12:0] pa_oe_next; // pad enable choice
   assign pa_gp_oe = pa_dir_reg[12:0] & 13'(`PIO_PA_PIN_MASK);
   // function bit hands the pad to the serial peripheral
   assign pa_o_next = (pa_func_reg[12:0] & PA_PERIPH_O) |
      (~pa_func_reg[12:0] & pa_val_reg[12:0]);
   assign pa_oe_next = (pa_func_reg[12:0] & PA_PERIPH_OE) |
      (~pa_func_reg[12:0] & pa_gp_oe);

   // ----------------------------------------------------------------
   // port A peripheral inputs
   // ----------------------------------------------------------------
   logic [12:0] pa_per_next; // level each peripheral input sees
   always_comb begin
      // general use ties the peripheral input low
      pa_per_next = pa_func_reg[12:0] & pa_sync[12:0];
      // line three general: the line two pad level then feeds the transmit clock input
      if (!pa_func_reg[`PIO_PA_TX_CLOCK_BIT]) begin
         pa_per_next[`PIO_PA_TX_CLOCK_BIT] =
            pa_sync[`PIO_PA_RX_CLOCK_BIT];
      end
   end

   // ----------------------------------------------------------------
   // port B pad drive and peripheral inputs
   // ----------------------------------------------------------------
   logic [11:0] pb_o_next; // pad level choice
   logic [11:0] pb_oe_next; // pad enable choice
   always_comb begin
      // general use first, absent positions never drive
      pb_o_next = pb_val_reg[11:0];
      pb_oe_next = pb_dir_reg[11:0] & 12'(`PIO_PB_PIN_MASK);
      // timer inputs take the pad as input only
      if (pb_func_reg[`PIO_PB_TIMER_ONE_BIT]) begin
         pb_oe_next[`PIO_PB_TIMER_ONE_BIT] = 1'b0;
      end
      if (pb_func_reg[`PIO_PB_TIMER_TWO_IN_BIT]) begin
         pb_oe_next[`PIO_PB_TIMER_TWO_IN_BIT] = 1'b0;
      end
      // timer two output drives push-pull
      if (pb_func_reg[`PIO_PB_TIMER_TWO_OUT_BIT]) begin
         pb_o_next[`PIO_PB_TIMER_TWO_OUT_BIT] = TIMER_TWO_OUTPUT;
         pb_oe_next[`PIO_PB_TIMER_TWO_OUT_BIT] = 1'b1;
      end
      // watchdog is open drain: only ever pulls the line low
      if (pb_func_reg[`PIO_PB_WATCHDOG_BIT]) begin
         pb_o_next[`PIO_PB_WATCHDOG_BIT] = 1'b0;
         pb_oe_next[`PIO_PB_WATCHDOG_BIT] = ~WATCHDOG_OUT_N;
      end
      // refresh use turns line eight into an input
      if (REFRESH_SELECT) begin
         pb_oe_next[`PIO_PB_LINE_EIGHT_BIT] = 1'b0;
      end
   end

   logic timer_one_next; // timer one input choice
   logic timer_two_next; // timer two input choice
   logic refresh_next; // refresh request choice
   assign timer_one_next = pb_func_reg[`PIO_PB_TIMER_ONE_BIT] &
      pb_sync[`PIO_PB_TIMER_ONE_BIT];
   assign timer_two_next = pb_func_reg[`PIO_PB_TIMER_TWO_IN_BIT] &
      pb_sync[`PIO_PB_TIMER_TWO_IN_BIT];
   assign refresh_next = REFRESH_SELECT &
      pb_sync[`PIO_PB_LINE_EIGHT_BIT];

   // ----------------------------------------------------------------
   // port N pad drive
   // ----------------------------------------------------------------
   logic pn_live; // port N pins exist in narrow mode
   logic [7:0] pn_oe_next; // pad enable choice
   assign pn_live = ~BUS_WIDTH_SELECT;
   // wide mode gives the pads to the data bus, so never drive them
   assign pn_oe_next = pn_live ? pn_dir_reg[15:8] : 8'h00;

   // ----------------------------------------------------------------
   // read values
   // ----------------------------------------------------------------
   pio_word_t pa_rd_next; // port A readback
   pio_word_t pb_rd_next; // port B readback
   pio_word_t pn_rd_next; // port N readback
   assign pa_rd_next = pio_read(pa_dir_reg, pa_val_reg, pa_sync,
      `PIO_PA_PIN_MASK);
   assign pb_rd_next = pio_read(pb_dir_reg, pb_val_reg, pb_sync,
      `PIO_PB_PIN_MASK);
   assign pn_rd_next = pn_live ? pio_read(pn_dir_reg, pn_val_reg,
      pn_sync, `PIO_PN_MASK) : 16'h0000;

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   // everything leaves through flops; a pad change lags one clock
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PA_PIN_O <= 13'h0000;
         PA_PIN_OE <= 13'h0000;
         PA_PERIPH_I <= 13'h0000;
         PB_PIN_O <= 12'h000;
         PB_PIN_OE <= 12'h000;
         PN_PIN_O <= 8'h00;
         PN_PIN_OE <= 8'h00;
         TIMER_ONE_INPUT <= 1'b0;
         TIMER_TWO_INPUT <= 1'b0;
         REFRESH_REQ <= 1'b0;
      end else begin
         PA_PIN_O <= pa_o_next;
         PA_PIN_OE <= pa_oe_next;
         PA_PERIPH_I <= pa_per_next;
         PB_PIN_O <= pb_o_next;
         PB_PIN_OE <= pb_oe_next;
         PN_PIN_O <= pn_val_reg[15:8];
         PN_PIN_OE <= pn_oe_next;
         TIMER_ONE_INPUT <= timer_one_next;
         TIMER_TWO_INPUT <= timer_two_next;
         REFRESH_REQ <= refresh_next;
      end
   end

   // readback registers
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PA_RD <= 16'h0000;
         PB_RD <= 16'h0000;
         PN_RD <= 16'h0000;
      end else begin
         PA_RD <= pa_rd_next;
         PB_RD <= pb_rd_next;
         PN_RD <= pn_rd_next;
      end
   end

   // configuration readback straight from the stored registers
   assign PA_FUNC_RD = pa_func_reg;
   assign PA_DIR_RD = pa_dir_reg;
   assign PB_FUNC_RD = pb_func_reg;
   assign PB_DIR_RD = pb_dir_reg;
   assign PN_DIR_RD = pn_dir_reg;

   // ----------------------------------------------------------------
   // clock mode strap on port A line twelve
   // ----------------------------------------------------------------
   logic strap_done_reg; // strap already taken
   logic strap_reg; // captured strap level
   // caught on the first edge after release, then the pin is general;
   // taken from the pad, as the synchronised copy still holds its
   // reset zero at that edge and would always read low
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         strap_done_reg <= 1'b0;
         strap_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         strap_reg <= PA_PIN_I[`PIO_PA_STRAP_BIT];
      end
   end
   assign CLOCK_MODE_STRAP = strap_reg;

   // ----------------------------------------------------------------
   // interrupt requests from lines 8-11
   // ----------------------------------------------------------------
   logic [3:0] irq_en; // lines allowed to request
   // tick timer owns the line eight slot; refresh use also silences it
   assign irq_en = ~pb_dir_reg[`PIO_PB_IRQ_LSB +: `PIO_PB_IRQ_W] &
      {3'h7, ~(PERIODIC_TICK_ENABLE | REFRESH_SELECT)};

   pio_edge u_edge (
      .MCLK (MCLK),
      .ARST_N (ARST_N),
      .level (pb_sync[`PIO_PB_IRQ_LSB +: `PIO_PB_IRQ_W]),
      .enable (irq_en),
      .request (PB_IRQ)
   );
endmodule : pio_ports
`default_nettype wire

// [sim/pio_ports_sva.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pio_consts.svh"
// ----
// port rules watched at the top module's pins
// ----
module pio_ports_sva (
   input wire logic MCLK, // clock
   input wire logic ARST_N, // reset, active low
   input wire logic [15:0] PA_FUNC_RD, // port a select
   input wire logic [15:0] PA_DIR_RD, // port a direction
   input wire logic [12:0] PA_PIN_OE, // port a enables
   input wire logic [12:0] PA_PERIPH_OE, // peripheral enables
   input wire logic [15:0] PB_FUNC_RD, // port b select
   input wire logic [15:0] PB_DIR_RD, // port b direction
   input wire logic [11:0] PB_PIN_I, // port b pads
   input wire logic [3:0] PB_IRQ, // line requests
   input wire logic PERIODIC_TICK_ENABLE, // tick timer on
   input wire logic TIMER_ONE_INPUT, // timer one feed
   input wire logic BUS_WIDTH_SELECT, // one means wide bus
   input wire logic [7:0] PN_PIN_OE, // port n enables
   input wire logic [15:0] PN_RD // port n readback
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   // a pad fall seen on an input line nine
   sequence l9_fall;
      !PB_DIR_RD[9] && $fell(PB_PIN_I[9]);
   endsequence
   reset_cfg_a: assert property (!$past(ARST_N) |->
      PA_FUNC_RD == 0 && PA_DIR_RD == 0 && PB_FUNC_RD == 16'h0080
      && PB_DIR_RD == 0) else $error("reset configuration wrong");
   pa_dir_a: assert property (((PA_PIN_OE ^ $past(PA_DIR_RD[12:0]))
      & ~$past(PA_FUNC_RD[12:0]) & 13'h17FF) == 0)
      else $error("port a enable not from direction");
   pa_periph_a: assert property (((PA_PIN_OE ^ $past(PA_PERIPH_OE))
      & $past(PA_FUNC_RD[12:0])) == 0) else $error("peripheral enable lost");
   rsv_zero_a: assert property ((PB_FUNC_RD & ~`PIO_PB_FUNC_MASK) == 0
      && (PA_FUNC_RD & ~`PIO_PA_FUNC_MASK) == 0 && PB_DIR_RD[15:12] == 0)
      else $error("reserved bit set");
   irq_pulse_a: assert property (PB_IRQ != 0 |=>
      (PB_IRQ & $past(PB_IRQ)) == 0) else $error("request longer than one");
   irq_cause_a: assert property (l9_fall |-> ##[2:6] PB_IRQ[1])
      else $error("line nine fall gave no request");
   tick_mask_a: assert property (PERIODIC_TICK_ENABLE [*6] |->
      !PB_IRQ[0]) else $error("line eight request with tick on");
   wide_off_a: assert property (BUS_WIDTH_SELECT [*2] |->
      PN_PIN_OE == 0 && PN_RD == 0) else $error("port n live in wide mode");
   timer_gp_a: assert property (!PB_FUNC_RD[3] [*4] |->
      !TIMER_ONE_INPUT) else $error("timer input not grounded");
endmodule : pio_ports_sva
bind pio_ports pio_ports_sva u_sva (.MCLK, .ARST_N, .PA_FUNC_RD, .PA_DIR_RD,
   .PA_PIN_OE, .PA_PERIPH_OE, .PB_FUNC_RD, .PB_DIR_RD, .PB_PIN_I, .PB_IRQ,
   .PERIODIC_TICK_ENABLE, .TIMER_ONE_INPUT, .BUS_WIDTH_SELECT, .PN_PIN_OE,
   .PN_RD);
`default_nettype wire

// [sim/pio_board.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// board side: a pad the device drives shows its level, else the board's
// ----
module pio_board (
   input wire logic [12:0] pa_o, // device drive
   input wire logic [12:0] pa_oe, // device enables
   input wire logic [12:0] pa_x, // board levels
   output logic [12:0] pa_i, // resolved pads
   input wire logic [11:0] pb_o, // device drive
   input wire logic [11:0] pb_oe, // device enables
   input wire logic [11:0] pb_x, // board levels
   output logic [11:0] pb_i, // resolved pads
   input wire logic [7:0] pn_o, // device drive
   input wire logic [7:0] pn_oe, // device enables
   input wire logic [7:0] pn_x, // board levels
   output logic [7:0] pn_i // resolved pads
);
   // per bit wire resolution, no contention modelled
   assign pa_i = (pa_oe & pa_o) | (~pa_oe & pa_x);
   assign pb_i = (pb_oe & pb_o) | (~pb_oe & pb_x);
   assign pn_i = (pn_oe & pn_o) | (~pn_oe & pn_x);
endmodule : pio_board
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pio_consts.svh"
module tb import pio_pkg::*;;
   `define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
      $display("Error at %0t: value mismatch", $time); end end
   logic mclk, arst_n, wr_en, two, wd_n, rsel, tick, bws;
   logic [2:0] wr_sel; // register picked
   logic [15:0] wr_data; // write data
   logic [12:0] pa_x, pa_po, pa_poe; // board and peripheral drive
   logic [11:0] pb_x; // board levels port b
   logic [7:0] pn_x; // board levels port n
   wire [15:0] pa_rd, pb_rd, pn_rd, pa_f, pa_d, pb_f, pb_d, pn_d;
   wire [12:0] pa_i, pa_o, pa_oe, pa_pi;
   wire [11:0] pb_i, pb_o, pb_oe;
   wire [7:0] pn_i, pn_o, pn_oe;
   wire [3:0] irq;
   wire t1, t2, rreq, strap;
   int n_errors, checked;
   logic [3:0] seen; // requests gathered over a window
   pio_ports DUT (.MCLK(mclk), .ARST_N(arst_n), .WR_EN(wr_en),
      .WR_SEL(wr_sel), .WR_DATA(wr_data), .PA_RD(pa_rd), .PB_RD(pb_rd),
      .PN_RD(pn_rd), .PA_FUNC_RD(pa_f), .PA_DIR_RD(pa_d), .PB_FUNC_RD(pb_f),
      .PB_DIR_RD(pb_d), .PN_DIR_RD(pn_d), .PA_PIN_I(pa_i), .PA_PIN_O(pa_o),
      .PA_PIN_OE(pa_oe), .PA_PERIPH_O(pa_po), .PA_PERIPH_OE(pa_poe),
      .PA_PERIPH_I(pa_pi), .PB_PIN_I(pb_i), .PB_PIN_O(pb_o),
      .PB_PIN_OE(pb_oe), .TIMER_TWO_OUTPUT(two), .WATCHDOG_OUT_N(wd_n),
      .TIMER_ONE_INPUT(t1), .TIMER_TWO_INPUT(t2), .REFRESH_SELECT(rsel),
      .REFRESH_REQ(rreq), .PERIODIC_TICK_ENABLE(tick), .PB_IRQ(irq),
      .PN_PIN_I(pn_i), .PN_PIN_O(pn_o), .PN_PIN_OE(pn_oe),
      .BUS_WIDTH_SELECT(bws), .CLOCK_MODE_STRAP(strap));
   pio_board u_brd (.pa_o(pa_o), .pa_oe(pa_oe), .pa_x(pa_x), .pa_i(pa_i),
      .pb_o(pb_o), .pb_oe(pb_oe), .pb_x(pb_x), .pb_i(pb_i), .pn_o(pn_o),
      .pn_oe(pn_oe), .pn_x(pn_x), .pn_i(pn_i));
   // ----
   // access tasks, all driving at the falling edge
   // ----
   task wt(input int n);
      repeat (n) @(negedge mclk);
   endtask : wt
   // one write, then room for pad, synchroniser and readback latency
   task wr(input pio_reg_t s, input logic [15:0] d);
      @(negedge mclk);
      wr_en = 1'b1;
      wr_sel = s;
      wr_data = d;
      @(negedge mclk);
      wr_en = 1'b0;
      wt(4);
   endtask : wr
   // a pulse stands one cycle, so exactly one falling edge catches it
   task watch;
      seen = 4'h0;
      repeat (8) @(negedge mclk) seen |= irq;
   endtask : watch
   task tally_and_finish;
      if (n_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // guard against a hang, far beyond the roughly 110 cycles needed
   initial begin
      #100000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      {arst_n, wr_en, wr_sel, wr_data, two, rsel, tick, bws} = '0;
      {pa_x, pa_po, pa_poe, pb_x, pn_x} = '0;
      wd_n = 1'b1;
      pa_x = 13'h1000;
      wt(3);
      arst_n = 1'b1;
      wt(1);
      `CHK(strap, 1'b1)
      `CHK(pa_f, 16'h0000)
      `CHK(pa_d, 16'h0000)
      `CHK(pb_f, `PIO_PB_FUNC_RST)
      `CHK(pb_d, 16'h0000)
      `CHK(pb_oe[7], 1'b0)
      wd_n = 1'b0;
      wt(4);
      `CHK(pb_oe[7], 1'b1)
      wd_n = 1'b1;
      // port a outputs, absent bit eleven reads back
      wr(PIO_REG_PA_DIR, 16'hFFFF);
      `CHK(pa_d, 16'h1FFF)
      wr(PIO_REG_PA_VAL, 16'h1A5A);
      `CHK(pa_rd, 16'h1A5A)
      `CHK(pa_o & 13'h17FF, 13'h125A)
      // port a inputs, peripheral feeds grounded but for the line two clock on line three
      pa_x = 13'h0F0F;
      wr(PIO_REG_PA_DIR, 16'h0000);
      `CHK(pa_rd, 16'h070F)
      `CHK(pa_pi, 13'h0008)
      // peripheral use: control port transmit drives line nine
      pa_po = 13'h0200;
      pa_poe = 13'h0200;
      wr(PIO_REG_PA_FUNC, 16'hFFFF);
      `CHK(pa_f, 16'h17FF)
      `CHK(pa_oe, 13'h0200)
      `CHK(pa_o[9], 1'b1)
      `CHK(pa_pi, 13'h070F)
      wr(PIO_REG_PA_FUNC, 16'h0000);
      // port b timer functions, then back to general use
      pb_x = 12'hF28;
      two = 1'b1;
      wr(PIO_REG_PB_FUNC, 16'hFFFF);
      `CHK(pb_f, 16'h00E8)
      `CHK({t1, t2}, 2'b11)
      `CHK(pb_oe[6] & pb_o[6], 1'b1)
      wr(PIO_REG_PB_FUNC, 16'h0000);
      `CHK({t1, t2}, 2'b00)
      wr(PIO_REG_PB_DIR, 16'hFFFF);
      `CHK(pb_d, 16'h0FFF)
      wr(PIO_REG_PB_VAL, 16'hFFFF);
      `CHK(pb_rd, 16'h0FFF)
      `CHK(pb_o[11:8], 4'hF)
      wr(PIO_REG_PB_DIR, 16'h0000);
      rsel = 1'b1;
      wt(4);
      `CHK(rreq, 1'b1)
      rsel = 1'b0;
      // falls on all four lines, line eight silenced by the tick timer
      tick = 1'b1;
      pb_x[11:8] = 4'h0;
      watch;
      `CHK(seen, 4'hE)
      tick = 1'b0;
      pb_x[11:8] = 4'hF;
      wt(4);
      pb_x[11:8] = 4'h0;
      watch;
      `CHK(seen, 4'hF)
      // port n in narrow mode, then switched off by wide mode
      wr(PIO_REG_PN_DIR, 16'hFFFF);
      `CHK(pn_d, 16'hFF00)
      wr(PIO_REG_PN_VAL, 16'hA5FF);
      `CHK(pn_o, 8'hA5)
      `CHK(pn_rd, 16'hA500)
      bws = 1'b1;
      wt(3);
      `CHK(pn_oe, 8'h00)
      `CHK(pn_rd, 16'h0000)
      tally_and_finish;
   end
endmodule : tb
`default_nettype wire
